// ==== hdl/ccs_pkg.sv ====
// constants shared by the cpu clock selection block
package ccs_pkg;
	// strap codes on the clock mode pins
	localparam logic [2:0] CCS_MODE_DIV2 = 3'h1;
	localparam logic [2:0] CCS_MODE_DIRECT = 3'h3;
	localparam logic [2:0] CCS_MODE_PLL_DEFAULT = 3'h7;
	localparam logic [2:0] CCS_MODE_RESET = 3'h7;
	// pll multiplication factors in eighths, per strap code
	localparam logic [5:0] CCS_F8_000 = 6'h03;
	localparam logic [5:0] CCS_F8_010 = 6'h0C;
	localparam logic [5:0] CCS_F8_100 = 6'h30;
	localparam logic [5:0] CCS_F8_101 = 6'h09;
	localparam logic [5:0] CCS_F8_110 = 6'h18;
	localparam logic [5:0] CCS_F8_111 = 6'h24;
	localparam logic [5:0] CCS_F8_NONE = 6'h00;
	// pll edges without an oscillator transition before it counts as lost
	localparam int CCS_OWD_LIMIT = 8;
	// peripheral divider select width, ratio is two to the select
	localparam int CCS_DIV_SEL_W = 3;
	localparam int CCS_PERIPH_N = 4;
	// source selection states
	typedef enum logic [3:0] {
		CCS_ST_BOOT = 4'h1,
		CCS_ST_OSC = 4'h2,
		CCS_ST_PLL = 4'h4,
		CCS_ST_EMERG = 4'h8
	} ccs_state_t;
endpackage : ccs_pkg

// ==== hdl/ccs_periph_div.sv ====
// one peripheral clock enable, a binary division of the cpu clock
`timescale 1ns/1ns
`default_nettype none
module ccs_periph_div
	import ccs_pkg::*;
#(
	parameter int SEL_W = CCS_DIV_SEL_W
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cpu_rise,
	input wire logic [SEL_W-1:0] div_sel,
	output logic periph_en
);
	localparam int CNT_W = (1 << SEL_W);
	// counter width doubles per select bit, so keep the select narrow
	if (SEL_W < 1 || SEL_W > 4)
	begin : g_bad_param
		$error("ccs_periph_div: unsupported select width");
	end
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] mask;
	logic hit;
	// ratio 2**div_sel: fire when the low div_sel bits are all ones
	assign mask = CNT_W'((CNT_W+1)'(1) << div_sel) - CNT_W'(1);
	assign hit = cpu_rise && ((cnt & mask) == mask);

	// free counter of cpu clock rising edges
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= '0;
			periph_en <= 1'b0;
		end
		else
		begin
			if (cpu_rise)
				cnt <= cnt + CNT_W'(1);
			periph_en <= hit;
		end
	end
endmodule : ccs_periph_div
`default_nettype wire

// ==== hdl/ccs_clock_select.sv ====
// cpu clock selection, oscillator watchdog and peripheral clock gating
// Operation
// - strap 001 at reset makes the cpu clock the oscillator divided by two.
// - in divide mode each cpu clock phase lasts one oscillator period.
// - strap 011 at reset passes the oscillator straight to the cpu clock.
// - in divide and direct modes pll clock edges supervise oscillator transitions.
// - missing oscillator transitions raise the interrupt and move cpu onto pll.
// - after an oscillator failure the pll runs at its basic free frequency.
// - watchdog enable low means no interrupt and cpu stays on oscillator.
// - once moved to pll the cpu returns to oscillator only by reset.
// - idle stops the core clock while the peripheral clock keeps running.
// - each peripheral gets its own binary division of the cpu clock.
// - lost input clock drops the pll to its basic frequency range, unless watchdog enable is low in divide or direct mode.
// - strap 111 selects default pll mode, factor 4.5, both dividers off.
`timescale 1ns/1ns
`default_nettype none
module ccs_clock_select
	import ccs_pkg::*;
#(
	parameter int OWD_LIMIT = CCS_OWD_LIMIT,
	parameter int PERIPH_N = CCS_PERIPH_N,
	parameter int SEL_W = CCS_DIV_SEL_W
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] clock_mode_pins,
	input wire logic crystal_input,
	input wire logic pll_clock,
	input wire logic osc_watchdog_int_enable,
	input wire logic idle_mode,
	input wire logic [PERIPH_N*SEL_W-1:0] periph_div_sel,
	output logic cpu_clock,
	output logic cpu_core_clock,
	output logic [PERIPH_N-1:0] periph_clk_en,
	output logic owd_irq,
	output logic pll_basic_mode,
	output logic [5:0] pll_factor_x8,
	output logic pll_dividers_off,
	output logic on_pll_clock
);
	localparam int CW = $clog2(OWD_LIMIT + 1);
	localparam logic [CW-1:0] LIMIT = CW'(OWD_LIMIT);

	// refuse settings the logic cannot serve, at elaboration
	if (OWD_LIMIT < 2 || PERIPH_N < 1 || SEL_W < 1 || SEL_W > 4)
	begin : g_bad_param
		$error("ccs_clock_select: unsupported parameter value");
	end

	logic [2:0] mode;
	logic mode_valid;
	logic osc_d;
	logic pll_d;
	logic div_q;
	logic cpu_prev;
	logic [CW-1:0] miss_cnt;
	logic miss_seen;
	ccs_state_t state;
	ccs_state_t next_state;
	logic next_cpu_clock;

	// strap capture on the first edge after reset release
	// latch once
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode <= CCS_MODE_RESET;
			mode_valid <= 1'b0;
		end
		else if (!mode_valid)
		begin
			mode <= clock_mode_pins;
			mode_valid <= 1'b1;
		end
	end

	// mode decode
	logic is_div2;
	logic is_direct;
	logic supervised;
	assign is_div2 = (mode == CCS_MODE_DIV2);
	assign is_direct = (mode == CCS_MODE_DIRECT);
	// watchdog switchover only where the oscillator drives the cpu
	assign supervised = is_div2 || is_direct;

	// edge detection on the sampled oscillator and pll levels
	logic osc_edge;
	logic osc_rise;
	logic pll_rise;
	logic cpu_rise;
	logic missing;
	assign osc_edge = crystal_input ^ osc_d;
	assign osc_rise = crystal_input & ~osc_d;
	assign pll_rise = pll_clock & ~pll_d;
	assign cpu_rise = cpu_clock & ~cpu_prev;
	assign missing = (miss_cnt == LIMIT);

	// pipeline registers and the 2:1 prescaler
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			osc_d <= 1'b0;
			pll_d <= 1'b0;
			div_q <= 1'b0;
			cpu_prev <= 1'b0;
		end
		else
		begin
			osc_d <= crystal_input;
			pll_d <= pll_clock;
			cpu_prev <= cpu_clock;
			if (osc_rise)
				div_q <= ~div_q;
		end
	end

	// watchdog: pll edges since the last oscillator transition
	// count pll edges
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			miss_cnt <= '0;
		else if (osc_edge)
			miss_cnt <= '0;
		else if (pll_rise && !missing)
			miss_cnt <= miss_cnt + CW'(1);
	end

	// source state machine
	always_comb
	begin
		next_state = state;
		unique case (state)
			CCS_ST_BOOT:
				if (mode_valid)
					next_state = supervised ? CCS_ST_OSC : CCS_ST_PLL;
			CCS_ST_OSC:
				// switch on loss, only when enabled
				if (missing && osc_watchdog_int_enable)
					next_state = CCS_ST_EMERG;
			CCS_ST_PLL:
				next_state = CCS_ST_PLL;
			CCS_ST_EMERG:
				next_state = CCS_ST_EMERG;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state <= CCS_ST_BOOT;
		else
			state <= next_state;
	end

	// cpu clock source selection
	always_comb
	begin
		next_cpu_clock = 1'b0;
		unique case (state)
			CCS_ST_BOOT:
				next_cpu_clock = 1'b0;
			CCS_ST_OSC:
				next_cpu_clock = is_div2 ? div_q : osc_d;
			CCS_ST_PLL:
				next_cpu_clock = pll_d;
			CCS_ST_EMERG:
				next_cpu_clock = pll_d;
		endcase
	end

	// clock outputs; the core copy is gated, the peripheral copy never is
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cpu_clock <= 1'b0;
			cpu_core_clock <= 1'b0;
		end
		else
		begin
			cpu_clock <= next_cpu_clock;
			cpu_core_clock <= next_cpu_clock & ~idle_mode;
		end
	end

	// interrupt pulse on the first cycle a loss is seen
	logic loss_event;
	assign loss_event = missing && !miss_seen && (state != CCS_ST_BOOT);
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			miss_seen <= 1'b0;
			owd_irq <= 1'b0;
			pll_basic_mode <= 1'b0;
		end
		else
		begin
			miss_seen <= missing;
			// request, suppressed while disabled
			// a switch always carries its request, even if enable rises during a standing loss
			owd_irq <= osc_watchdog_int_enable && (loss_event || (state == CCS_ST_OSC && missing));
			// sticky after the switch, follows loss in pll modes
			if (next_state == CCS_ST_EMERG)
				pll_basic_mode <= 1'b1;
			else if (state == CCS_ST_PLL)
				pll_basic_mode <= missing;
		end
	end

	// pll factor per strap, in eighths; none in oscillator modes
	// default mode 111 is 4.5 with dividers off
	always_comb
	begin
		pll_factor_x8 = CCS_F8_NONE;
		unique case (mode)
			3'h0: pll_factor_x8 = CCS_F8_000;
			3'h2: pll_factor_x8 = CCS_F8_010;
			3'h4: pll_factor_x8 = CCS_F8_100;
			3'h5: pll_factor_x8 = CCS_F8_101;
			3'h6: pll_factor_x8 = CCS_F8_110;
			3'h7: pll_factor_x8 = CCS_F8_111;
			default: pll_factor_x8 = CCS_F8_NONE;
		endcase
	end
	assign pll_dividers_off = (mode != 3'h0) && (mode != 3'h5) && !is_div2;
	assign on_pll_clock = (state == CCS_ST_PLL) || (state == CCS_ST_EMERG);

	// per-peripheral dividers run from the ungated cpu clock
	// one divider each
	genvar gi;
	generate
		for (gi = 0; gi < PERIPH_N; gi++)
		begin : g_periph
			ccs_periph_div #(
				.SEL_W(SEL_W)
			) u_div (
				.clk(clk),
				.rst_n(rst_n),
				.cpu_rise(cpu_rise),
				.div_sel(periph_div_sel[gi*SEL_W +: SEL_W]),
				.periph_en(periph_clk_en[gi])
			);
		end
	endgenerate

	// checks on the selection logic
	a_strap_held: assert property (@(posedge clk) disable iff (!rst_n)
		mode_valid |=> $stable(mode))
		else $error("mode changed after capture");
	a_div_phase: assert property (@(posedge clk) disable iff (!rst_n)
		(state == CCS_ST_OSC && is_div2 && osc_rise) |=> (div_q != $past(div_q)))
		else $error("prescaler did not toggle on oscillator rise");
	a_div_output: assert property (@(posedge clk) disable iff (!rst_n)
		(state == CCS_ST_OSC && is_div2) |=> (cpu_clock == $past(div_q)))
		else $error("divide mode cpu clock wrong");
	a_direct_out: assert property (@(posedge clk) disable iff (!rst_n)
		(state == CCS_ST_OSC && is_direct) |-> ##1 (cpu_clock == $past(osc_d)))
		else $error("direct mode cpu clock wrong");
	a_switch_pll: assert property (@(posedge clk) disable iff (!rst_n)
		(state == CCS_ST_OSC && missing && osc_watchdog_int_enable) |=> owd_irq && state == CCS_ST_EMERG)
		else $error("loss did not raise interrupt and switch");
	a_disabled_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		(!$past(osc_watchdog_int_enable) && $past(state) == CCS_ST_OSC) |-> !owd_irq && state == CCS_ST_OSC)
		else $error("disabled watchdog acted");
	a_stay_pll: assert property (@(posedge clk) disable iff (!rst_n)
		(state == CCS_ST_EMERG) |=> (state == CCS_ST_EMERG) && pll_basic_mode)
		else $error("left emergency pll without reset");
	a_basic_freq: assert property (@(posedge clk) disable iff (!rst_n)
		(state == CCS_ST_EMERG) |-> pll_basic_mode && on_pll_clock)
		else $error("pll not in basic mode after failure");
	a_idle_gate: assert property (@(posedge clk) disable iff (!rst_n)
		$past(idle_mode) |-> !cpu_core_clock)
		else $error("core clock ran in idle");
	a_watch_count: assert property (@(posedge clk) disable iff (!rst_n)
		osc_edge |=> (miss_cnt == '0))
		else $error("watchdog count not cleared by oscillator edge");
	a_default_mode: assert property (@(posedge clk) disable iff (!rst_n)
		(mode == CCS_MODE_PLL_DEFAULT) |-> (pll_factor_x8 == CCS_F8_111) && pll_dividers_off)
		else $error("default pll mode factor wrong");
	a_loss_basic: assert property (@(posedge clk) disable iff (!rst_n)
		(state == CCS_ST_PLL && missing) |=> pll_basic_mode)
		else $error("pll not dropped to basic on loss");
	a_irq_single: assert property (@(posedge clk) disable iff (!rst_n)
		owd_irq |=> !owd_irq)
		else $error("watchdog request longer than one cycle");
	a_pll_source: assert property (@(posedge clk) disable iff (!rst_n)
		(state == CCS_ST_EMERG) |=> (cpu_clock == $past(pll_d)))
		else $error("cpu clock not taken from pll after failure");
	a_core_follow: assert property (@(posedge clk) disable iff (!rst_n)
		!$past(idle_mode) |-> (cpu_core_clock == cpu_clock))
		else $error("core clock differs from cpu clock outside idle");
endmodule : ccs_clock_select
`default_nettype wire

// ==== tb/ccs_osc_model.sv ====
// crystal and free-running pll clock sources for the clock select bench
`timescale 1ns/1ns
`default_nettype none
module ccs_osc_model
(
	input wire logic clk,
	input wire logic osc_run,
	input wire logic [3:0] osc_half,
	output logic crystal_input,
	output logic pll_clock
);
	logic [3:0] cnt;
	wire wrap = (cnt + 4'h1) >= osc_half;
	// a stopped crystal keeps its last level, as a dead oscillator does
	initial
	begin
		crystal_input = 1'b0;
		pll_clock = 1'b0;
		cnt = 4'h0;
	end
	// pll toggles every clk whatever the crystal does, so it can supervise it
	always @(negedge clk)
	begin
		pll_clock <= ~pll_clock;
		if (osc_run)
		begin
			cnt <= wrap ? 4'h0 : cnt + 4'h1;
			if (wrap)
				crystal_input <= ~crystal_input;
		end
	end
endmodule : ccs_osc_model
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the cpu clock selection block
`timescale 1ns/1ns
`default_nettype none
module tb
	import ccs_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] clock_mode_pins = CCS_MODE_DIRECT;
	logic osc_run = 1'b1;
	logic [3:0] osc_half = 4'h2;
	logic osc_watchdog_int_enable = 1'b0;
	logic idle_mode = 1'b0;
	logic [11:0] periph_div_sel = 12'h000;
	wire crystal_input, pll_clock, cpu_clock, cpu_core_clock, owd_irq;
	wire pll_basic_mode, pll_dividers_off, on_pll_clock;
	wire [3:0] periph_clk_en;
	wire [5:0] pll_factor_x8;
	int n_mismatch = 0;
	int comparisons = 0;
	logic [7:0] n;
	int cnt[4];
	int hi_core, hi_cpu, irqs;

	always #25 clk = ~clk;

	ccs_osc_model osc (.clk(clk), .osc_run(osc_run), .osc_half(osc_half),
		.crystal_input(crystal_input), .pll_clock(pll_clock));
	ccs_clock_select dut (.clk(clk), .rst_n(rst_n), .clock_mode_pins(clock_mode_pins),
		.crystal_input(crystal_input), .pll_clock(pll_clock),
		.osc_watchdog_int_enable(osc_watchdog_int_enable), .idle_mode(idle_mode),
		.periph_div_sel(periph_div_sel), .cpu_clock(cpu_clock), .cpu_core_clock(cpu_core_clock),
		.periph_clk_en(periph_clk_en), .owd_irq(owd_irq), .pll_basic_mode(pll_basic_mode),
		.pll_factor_x8(pll_factor_x8), .pll_dividers_off(pll_dividers_off), .on_pll_clock(on_pll_clock));

	// one comparison, counted, mismatch reported at once
	task check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict

	// straps stay put through the first edge after release, where they are caught
	task do_reset(input logic [2:0] mode, input logic en);
		@(negedge clk);
		rst_n = 1'b0;
		clock_mode_pins = mode;
		osc_watchdog_int_enable = en;
		osc_run = 1'b1;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		repeat (8) @(negedge clk);
	endtask : do_reset

	// length in clk cycles of one full cpu clock phase, bounded wait
	task half_period(output logic [7:0] len);
		logic lvl;
		int i;
		lvl = cpu_clock;
		i = 0;
		while (cpu_clock === lvl && i < 100)
		begin
			@(negedge clk);
			i++;
		end
		lvl = cpu_clock;
		len = 8'h00;
		while (cpu_clock === lvl && len < 8'hFF)
		begin
			@(negedge clk);
			len++;
		end
	endtask : half_period

	task test_div2;
		do_reset(CCS_MODE_DIV2, 1'b0);
		clock_mode_pins = CCS_MODE_DIRECT;
		repeat (2)
		begin
			half_period(n);
			check(n, 8'h04);
		end
		check({2'h0, pll_factor_x8}, 8'h00);
		$display("divide test done");
	endtask : test_div2

	task test_direct_idle_periph;
		do_reset(CCS_MODE_DIRECT, 1'b0);
		half_period(n);
		check(n, 8'h02);
		check({7'h0, on_pll_clock}, 8'h00);
		idle_mode = 1'b1;
		periph_div_sel = {3'h3, 3'h2, 3'h1, 3'h0};
		repeat (8) @(negedge clk);
		hi_core = 0;
		hi_cpu = 0;
		cnt = '{0, 0, 0, 0};
		repeat (128)
		begin
			@(negedge clk);
			hi_core += cpu_core_clock;
			hi_cpu += cpu_clock;
			for (int i = 0; i < 4; i++)
				cnt[i] += periph_clk_en[i];
		end
		check(hi_core[7:0], 8'h00);
		check(hi_cpu[7:0], 8'h40);
		// 32 cpu rises in the window, one pulse of slack for phase
		for (int i = 0; i < 4; i++)
			check({7'h0, (cnt[i] >= (32 >> i) - 1) && (cnt[i] <= (32 >> i) + 1)}, 8'h01);
		idle_mode = 1'b0;
		$display("direct idle peripheral test done");
	endtask : test_direct_idle_periph

	task test_watchdog(input logic en);
		do_reset(CCS_MODE_DIRECT, en);
		osc_run = 1'b0;
		irqs = 0;
		repeat (60)
		begin
			@(negedge clk);
			irqs += owd_irq;
		end
		check(irqs[7:0], {7'h0, en});
		check({7'h0, on_pll_clock}, {7'h0, en});
		check({7'h0, pll_basic_mode}, {7'h0, en});
		osc_run = 1'b1;
		repeat (40) @(negedge clk);
		check({7'h0, on_pll_clock}, {7'h0, en});
		if (en)
		begin
			half_period(n);
			check(n, 8'h01);
			do_reset(CCS_MODE_DIRECT, en);
			check({6'h0, on_pll_clock, pll_basic_mode}, 8'h00);
		end
		$display("watchdog test done, enable %0d", en);
	endtask : test_watchdog

	// every pll strap code, ending on the default mode, then a lost crystal there
	task test_pll_default;
		logic [5:0] f8[8];
		f8 = '{CCS_F8_000, CCS_F8_NONE, CCS_F8_010, CCS_F8_NONE, CCS_F8_100, CCS_F8_101, CCS_F8_110, CCS_F8_111};
		for (int m = 0; m < 8; m++)
		begin
			if (m != 1 && m != 3)
			begin
				do_reset(3'(m), 1'b0);
				check({2'h0, pll_factor_x8}, {2'h0, f8[m]});
				check({6'h0, pll_dividers_off, on_pll_clock}, {6'h0, m != 0 && m != 5, 1'b1});
			end
		end
		check({2'h0, pll_factor_x8}, 8'h24);
		osc_run = 1'b0;
		repeat (60) @(negedge clk);
		check({6'h0, pll_basic_mode, on_pll_clock}, 8'h03);
		osc_run = 1'b1;
		repeat (20) @(negedge clk);
		check({7'h0, pll_basic_mode}, 8'h00);
		$display("default pll test done");
	endtask : test_pll_default

	// the whole run is well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		print_verdict();
	end

	initial
	begin
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		test_div2();
		test_direct_idle_periph();
		test_watchdog(1'b1);
		test_watchdog(1'b0);
		test_pll_default();
		print_verdict();
	end
endmodule : tb
`default_nettype wire
